/* File: src/adcsq_ctrl.sv */
// Eight-channel 8-bit converter sequencer with register file and trigger input
`timescale 1ns/1ps
`include "adcsq_map.svh"
module adcsq_ctrl #(
    parameter int NUM_RESULTS = 4
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic standby_enter,
    input wire logic [15:0] bus_addr,
    input wire adcsq_pkg::adcsq_byte_t bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output adcsq_pkg::adcsq_byte_t bus_rdata,
    input wire logic ext_trigger_n,
    input wire logic core_compare,
    output logic [2:0] core_channel,
    output logic core_sample,
    output adcsq_pkg::adcsq_byte_t core_trial,
    output logic conv_done_irq
);
    import adcsq_pkg::*;

    // Derived sample lengths; first conversion allows two cycles of start latency
    localparam int BIT_SLOW = `ADCSQ_NUM_BITS * `ADCSQ_TRIAL_SLOW;
    localparam int BIT_FAST = `ADCSQ_NUM_BITS * `ADCSQ_TRIAL_FAST;
    localparam logic [7:0] FIRST_SMP_SLOW = 8'(`ADCSQ_CONV_MAX_SLOW - BIT_SLOW - 2);
    localparam logic [7:0] FIRST_SMP_FAST = 8'(`ADCSQ_CONV_MAX_FAST - BIT_FAST - 2);
    localparam logic [7:0] NEXT_SMP_SLOW = 8'(`ADCSQ_SCAN_LEN_SLOW - BIT_SLOW - 1);
    localparam logic [7:0] NEXT_SMP_FAST = 8'(`ADCSQ_SCAN_LEN_FAST - BIT_FAST - 1);
    localparam logic [4:0] TRIAL_SLOW = 5'(`ADCSQ_TRIAL_SLOW);
    localparam logic [4:0] TRIAL_FAST = 5'(`ADCSQ_TRIAL_FAST);

    adcsq_sar_if sar_bus ();

    adcsq_sar u_sar (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .sar(sar_bus.engine)
    );

    // Control/status fields
    logic conv_done_flag;
    logic done_irq_enable;
    logic conv_start_bit;
    adcsq_mode_t conv_mode;
    logic conv_speed_select;
    logic group_select;
    logic channel_select_hi;
    logic channel_select_lo;
    logic done_read_armed;
    // Trigger control fields
    logic ext_trigger_enable;
    logic spare_bit0;
    logic trigger_prev_n;
    // Sequencer
    adcsq_state_t state;
    logic first_conv;
    logic [2:0] cur_chan;
    adcsq_byte_t results [NUM_RESULTS];

    // Address decode
    wire sel_csr = (bus_addr == `ADCSQ_ADDR_CSR);
    wire sel_tcr = (bus_addr == `ADCSQ_ADDR_TCR);
    wire sel_res_a = (bus_addr == `ADCSQ_ADDR_RESULT_A);
    wire sel_res_b = (bus_addr == `ADCSQ_ADDR_RESULT_B);
    wire sel_res_c = (bus_addr == `ADCSQ_ADDR_RESULT_C);
    wire sel_res_d = (bus_addr == `ADCSQ_ADDR_RESULT_D);
    wire wr_csr = bus_wr && sel_csr;
    wire wr_tcr = bus_wr && sel_tcr;
    wire rd_csr = bus_rd && sel_csr;

    // Register images as read back
    wire [1:0] chan_low = {channel_select_hi, channel_select_lo};
    wire [7:0] csr_image = {conv_done_flag, done_irq_enable, conv_start_bit, conv_mode,
                            conv_speed_select, group_select, chan_low};
    wire [7:0] tcr_image = {ext_trigger_enable, `ADCSQ_TCR_FIXED_ONES, spare_bit0};
    wire [7:0] read_mux = sel_csr ? csr_image :
                          sel_tcr ? tcr_image :
                          sel_res_a ? results[0] :
                          sel_res_b ? results[1] :
                          sel_res_c ? results[2] :
                          sel_res_d ? results[3] : `ADCSQ_READ_IDLE;

    // Sequencer decisions
    wire is_scan = (conv_mode == ADCSQ_SCAN);
    wire converting = (state == ADCSQ_CONV);
    wire conv_end = converting && sar_bus.done && conv_start_bit;
    wire last_in_scan = (cur_chan[1:0] == chan_low);
    wire scan_relaunch = conv_end && is_scan;
    wire [2:0] first_chan = is_scan ? {group_select, 2'b00} : {group_select, chan_low};
    wire [2:0] next_chan = last_in_scan ? first_chan : {cur_chan[2], cur_chan[1:0] + 2'b01};

    wire trigger_fall = trigger_prev_n && !ext_trigger_n;
    wire trig_set = ext_trigger_enable && trigger_fall;

    // done on single end or last scan channel
    wire done_set = conv_end && (!is_scan || last_in_scan);
    // clear only after armed read, zero write
    wire done_clear = wr_csr && !bus_wdata[`ADCSQ_CSR_DONE] && done_read_armed;
    // Set wins over clear
    wire next_done = done_set || (conv_done_flag && !done_clear);
    // single mode start self-clears at end
    wire start_hw_clear = conv_end && !is_scan;
    wire next_start = trig_set || (wr_csr ? bus_wdata[`ADCSQ_CSR_START] : (conv_start_bit && !start_hw_clear));
    wire next_armed = rd_csr ? conv_done_flag : (wr_csr ? 1'b0 : done_read_armed);

    // speed picks trial and first sample lengths
    wire [4:0] trial_len = conv_speed_select ? TRIAL_FAST : TRIAL_SLOW;
    wire [7:0] first_len = conv_speed_select ? FIRST_SMP_FAST : FIRST_SMP_SLOW;
    wire [7:0] next_len = conv_speed_select ? NEXT_SMP_FAST : NEXT_SMP_SLOW;

    // Engine hookup
    // start low aborts and holds engine idle
    // standby stops the engine at once
    // Otherwise a running engine outlives standby and hijacks the next start
    assign sar_bus.abort = (converting && !conv_start_bit) || standby_enter;
    assign sar_bus.start = ((state == ADCSQ_IDLE) && conv_start_bit) || scan_relaunch;
    assign sar_bus.sample_len = scan_relaunch ? next_len : first_len;
    assign sar_bus.trial_len = trial_len;
    assign sar_bus.compare = core_compare;

    // analog core driven from engine flops and the sequencer channel pointer
    assign core_sample = sar_bus.sample;
    assign core_trial = sar_bus.word;
    assign core_channel = cur_chan;
    assign conv_done_irq = conv_done_flag && done_irq_enable;

    // Control/status register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            {conv_done_flag, done_irq_enable, conv_start_bit} <= 3'b000;
            conv_mode <= ADCSQ_SINGLE;
            {conv_speed_select, group_select, channel_select_hi, channel_select_lo} <= 4'h0;
            done_read_armed <= 1'b0;
        end else if (standby_enter) begin
            {conv_done_flag, done_irq_enable, conv_start_bit} <= 3'b000;
            conv_mode <= ADCSQ_SINGLE;
            {conv_speed_select, group_select, channel_select_hi, channel_select_lo} <= 4'h0;
            done_read_armed <= 1'b0;
        end else begin
            conv_done_flag <= next_done;
            conv_start_bit <= next_start;
            done_read_armed <= next_armed;
            if (wr_csr) begin
                done_irq_enable <= bus_wdata[`ADCSQ_CSR_IRQ_EN];
                conv_mode <= adcsq_mode_t'(bus_wdata[`ADCSQ_CSR_MODE]);
                conv_speed_select <= bus_wdata[`ADCSQ_CSR_SPEED];
                group_select <= bus_wdata[`ADCSQ_CSR_GROUP];
                {channel_select_hi, channel_select_lo} <= bus_wdata[1:0];
            end
        end
    end

    // Trigger control register and edge history
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_trigger_enable <= 1'b0;
            spare_bit0 <= 1'b0;
            trigger_prev_n <= 1'b1;
        end else if (standby_enter) begin
            ext_trigger_enable <= 1'b0;
            spare_bit0 <= 1'b0;
            trigger_prev_n <= 1'b1;
        end else begin
            trigger_prev_n <= ext_trigger_n;
            if (wr_tcr) begin
                ext_trigger_enable <= bus_wdata[`ADCSQ_TCR_TRG_EN];
                spare_bit0 <= bus_wdata[`ADCSQ_TCR_SPARE];
            end
        end
    end

    // Sequencer state, channel pointer and first-conversion marker
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ADCSQ_IDLE;
            first_conv <= 1'b1;
            cur_chan <= 3'h0;
        end else begin
            case (state)
                ADCSQ_IDLE: begin
                    if (conv_start_bit && !standby_enter) begin
                        state <= ADCSQ_CONV;
                        first_conv <= 1'b1;
                        cur_chan <= first_chan;
                    end
                end
                ADCSQ_CONV: begin
                    if (!conv_start_bit || standby_enter) begin
                        state <= ADCSQ_IDLE;
                    end else if (sar_bus.done && !is_scan) begin
                        state <= ADCSQ_IDLE;
                    end else if (sar_bus.done) begin
                        // step through group, wrapping to first channel after last
                        first_conv <= 1'b0;
                        cur_chan <= next_chan;
                    end
                end
                default: begin
                    state <= ADCSQ_IDLE;
                end
            endcase
        end
    end

    // results land in register by channel low bits
    // both groups share the four registers
    for (genvar i = 0; i < NUM_RESULTS; i++) begin : g_result
        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                results[i] <= `ADCSQ_RESULT_RESET;
            end else if (standby_enter) begin
                results[i] <= `ADCSQ_RESULT_RESET;
            end else if (conv_end && (cur_chan[1:0] == 2'(i))) begin
                results[i] <= sar_bus.word;
            end
        end
    end

    // Read data stand for one cycle after the strobe
    // fixed ones appear in trigger image
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_rdata <= `ADCSQ_READ_IDLE;
        end else begin
            bus_rdata <= bus_rd ? read_mux : `ADCSQ_READ_IDLE;
        end
    end

    // Helper count of engine busy cycles
    logic [8:0] busy_cnt;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_cnt <= 9'h000;
        end else if (sar_bus.start && !sar_bus.busy) begin
            busy_cnt <= 9'h000;
        end else if (sar_bus.busy) begin
            busy_cnt <= busy_cnt + 9'h001;
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    chk_irq_gate: assert property (
        conv_done_flag && done_irq_enable |-> conv_done_irq) else $error("irq missing with flag and enable");
    chk_irq_masked: assert property (
        !done_irq_enable |-> !conv_done_irq) else $error("irq raised while disabled");
    chk_done_sticky: assert property (
        conv_done_flag && !wr_csr && !standby_enter |=> conv_done_flag) else $error("done flag lost");
    chk_done_one_ignored: assert property (
        !conv_done_flag && wr_csr && !done_set |=> !conv_done_flag) else $error("write set done flag");
    chk_single_slow_len: assert property (
        $rose(conv_start_bit) && !is_scan && !conv_speed_select && !bus_wr && !standby_enter
        |-> ##[1:242] !conv_start_bit) else $error("slow single conversion too long");
    chk_single_fast_len: assert property (
        $rose(conv_start_bit) && !is_scan && conv_speed_select && !bus_wr && !standby_enter
        |-> ##[1:122] !conv_start_bit) else $error("fast single conversion too long");
    chk_single_autostop: assert property (
        conv_end && !is_scan && !trig_set && !wr_csr && !standby_enter |=> !conv_start_bit && conv_done_flag)
        else $error("single mode did not stop");
    chk_halt_abort: assert property (
        converting && !conv_start_bit |=> !sar_bus.busy ##1 !sar_bus.busy) else $error("engine runs while halted");
    chk_tcr_fixed_ones: assert property (
        bus_rd && sel_tcr |=> bus_rdata[6:1] == 6'h3F) else $error("trigger reserved bits not ones");
    chk_standby_clear: assert property (
        standby_enter |=> results[0] == 8'h00 && results[3] == 8'h00 && csr_image == 8'h00)
        else $error("standby did not clear registers");
    chk_scan_restart: assert property (
        state == ADCSQ_IDLE && conv_start_bit && is_scan && !standby_enter |=> cur_chan[1:0] == 2'b00)
        else $error("scan did not restart at first channel");
    chk_trigger_start: assert property (
        trig_set && !standby_enter |=> conv_start_bit) else $error("trigger edge did not set start");
    chk_scan_period: assert property (
        sar_bus.done && is_scan && !first_conv && converting
        |-> busy_cnt == (conv_speed_select ? 9'h07F : 9'h0FF)) else $error("scan conversion length wrong");

    // Read path, standby stop, halt and channel sequencing
    chk_rd_result: assert property (
        bus_rd && sel_res_a |=> bus_rdata == $past(results[0])) else $error("result read mismatch");
    chk_result_hold: assert property (
        !conv_end && !standby_enter |=> $stable(results[1])) else $error("result changed without conversion");
    chk_standby_stop: assert property (
        standby_enter |=> !core_sample && !sar_bus.busy) else $error("engine runs after standby");
    chk_halt_no_sample: assert property (
        !conv_start_bit |=> !core_sample) else $error("sampling while start low");
    chk_trial_first: assert property (
        sar_bus.start && !sar_bus.busy && !sar_bus.abort |=> core_sample && core_trial == 8'h80)
        else $error("conversion did not open with sample and top trial");
    chk_scan_wrap: assert property (
        conv_end && is_scan && last_in_scan && !standby_enter |=> core_channel[1:0] == 2'b00 && sar_bus.busy)
        else $error("scan did not wrap and continue");
    chk_trig_off: assert property (
        !ext_trigger_enable && !conv_start_bit && !wr_csr && !standby_enter |=> !conv_start_bit)
        else $error("start set with trigger disabled");
    chk_single_channel: assert property (
        state == ADCSQ_IDLE && conv_start_bit && !is_scan && !standby_enter && !wr_csr
        |=> core_channel == {group_select, chan_low}) else $error("single channel decode wrong");

    cov_single_done: cover property (conv_end && !is_scan);
    cov_scan_cycle: cover property (done_set && is_scan && chan_low == 2'b11);
    cov_trigger_start: cover property (trig_set);
    cov_done_cleared: cover property (conv_done_flag && done_clear);
    cov_standby_abort: cover property (standby_enter && converting);
endmodule

/* File: src/adcsq_map.svh */
// Register offsets, field positions, reset values and timing counts of the converter block
`ifndef ADCSQ_MAP_SVH
`define ADCSQ_MAP_SVH

// Byte addresses on the CPU bus
`define ADCSQ_ADDR_RESULT_A 16'hFFE0
`define ADCSQ_ADDR_RESULT_B 16'hFFE2
`define ADCSQ_ADDR_RESULT_C 16'hFFE4
`define ADCSQ_ADDR_RESULT_D 16'hFFE6
`define ADCSQ_ADDR_CSR 16'hFFE8
`define ADCSQ_ADDR_TCR 16'hFFEA

// Control/status field positions
`define ADCSQ_CSR_DONE 7
`define ADCSQ_CSR_IRQ_EN 6
`define ADCSQ_CSR_START 5
`define ADCSQ_CSR_MODE 4
`define ADCSQ_CSR_SPEED 3
`define ADCSQ_CSR_GROUP 2

// Trigger control field positions and fixed bits
`define ADCSQ_TCR_TRG_EN 7
`define ADCSQ_TCR_SPARE 0
`define ADCSQ_TCR_FIXED_ONES 6'h3F

// Reset values
`define ADCSQ_CSR_RESET 8'h00
`define ADCSQ_TCR_RESET 8'h7E
`define ADCSQ_RESULT_RESET 8'h00
`define ADCSQ_READ_IDLE 8'h00

// Conversion lengths in states (one state is one sys_clk cycle)
`define ADCSQ_CONV_MAX_SLOW 242
`define ADCSQ_CONV_MAX_FAST 122
`define ADCSQ_SCAN_LEN_SLOW 256
`define ADCSQ_SCAN_LEN_FAST 128
`define ADCSQ_TRIAL_SLOW 16
`define ADCSQ_TRIAL_FAST 8
`define ADCSQ_NUM_BITS 8

`endif

/* File: src/adcsq_pkg.sv */
// Types shared by the converter control modules
package adcsq_pkg;
    typedef logic [7:0] adcsq_byte_t;
    typedef enum logic [0:0] {ADCSQ_IDLE = 1'b0, ADCSQ_CONV = 1'b1} adcsq_state_t;
    typedef enum logic [0:0] {ADCSQ_SINGLE = 1'b0, ADCSQ_SCAN = 1'b1} adcsq_mode_t;
endpackage

/* File: src/adcsq_sar.sv */
// Successive-approximation bit-trial engine
`timescale 1ns/1ps
module adcsq_sar (
    input wire logic sys_clk,
    input wire logic reset_n,
    adcsq_sar_if.engine sar
);
    import adcsq_pkg::*;

    logic busy;
    logic sampling;
    logic done;
    logic [7:0] cnt;
    logic [2:0] bit_idx;
    adcsq_byte_t word;

    // Trial masks and next working word
    wire [7:0] bit_mask = 8'h01 << bit_idx;
    wire [7:0] lower_mask = bit_mask >> 1;
    wire [7:0] next_word = (sar.compare ? word : (word & ~bit_mask)) | lower_mask;
    wire last_count = (cnt == 8'h01);

    assign sar.busy = busy;
    assign sar.done = done;
    assign sar.sample = sampling;
    assign sar.word = word;

    // Sample phase then eight trials, one bit each
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy <= 1'b0;
            sampling <= 1'b0;
            done <= 1'b0;
            cnt <= 8'h00;
            bit_idx <= 3'h0;
            word <= 8'h00;
        end else begin
            done <= 1'b0;
            if (sar.abort) begin
                busy <= 1'b0;
                sampling <= 1'b0;
            end else if (!busy && sar.start) begin
                busy <= 1'b1;
                sampling <= 1'b1;
                cnt <= sar.sample_len;
                bit_idx <= 3'h7;
                word <= 8'h80;
            end else if (busy && last_count && sampling) begin
                sampling <= 1'b0;
                cnt <= {3'h0, sar.trial_len};
            end else if (busy && last_count) begin
                word <= next_word;
                cnt <= {3'h0, sar.trial_len};
                if (bit_idx == 3'h0) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    bit_idx <= bit_idx - 3'h1;
                end
            end else if (busy) begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule

/* File: src/adcsq_sar_if.sv */
// Carrier between the sequencer and the bit-trial engine
`timescale 1ns/1ps
interface adcsq_sar_if;
    logic start;
    logic abort;
    logic [7:0] sample_len;
    logic [4:0] trial_len;
    logic compare;
    logic busy;
    logic done;
    logic sample;
    logic [7:0] word;
    modport ctrl (output start, abort, sample_len, trial_len, compare, input busy, done, sample, word);
    modport engine (input start, abort, sample_len, trial_len, compare, output busy, done, sample, word);
endinterface

/* File: tb/adcsq_core_model.sv */
// Behavioural sample-and-hold and comparator standing in for the analog core
`timescale 1ns/1ps
module adcsq_core_model (
    input wire logic sys_clk,
    input wire logic [63:0] levels,
    input wire logic [2:0] core_channel,
    input wire logic core_sample,
    input wire adcsq_pkg::adcsq_byte_t core_trial,
    output logic core_compare
);
    import adcsq_pkg::*;
    adcsq_byte_t held;
    // hold the level of the selected input
    always @(posedge sys_clk) begin
        if (core_sample) begin
            held <= levels[core_channel*8 +: 8];
        end
    end
    // keep the bit while input is not below the trial word
    assign core_compare = (held >= core_trial);
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`include "adcsq_map.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top;
    import adcsq_pkg::*;
    logic sys_clk = 0, reset_n = 0, standby_enter = 0, bus_wr = 0, bus_rd = 0, ext_trigger_n = 1, samp_d = 0;
    logic [15:0] bus_addr = 16'h0000;
    adcsq_byte_t bus_wdata = 8'h00, bus_rdata, core_trial, rv;
    logic core_compare, core_sample, conv_done_irq;
    logic [2:0] core_channel;
    logic [63:0] levels = 64'h0;
    int failures = 0, compares = 0, cyc = 0, n, base, i, seed = 32'hf9b433fb;
    int lvl [8];
    int rise_t [$];
    int rise_ch [$];
    adcsq_ctrl i_adcsq_ctrl (.sys_clk(sys_clk), .reset_n(reset_n), .standby_enter(standby_enter),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .ext_trigger_n(ext_trigger_n), .core_compare(core_compare), .core_channel(core_channel),
        .core_sample(core_sample), .core_trial(core_trial), .conv_done_irq(conv_done_irq));
    adcsq_core_model i_adcsq_core_model (.sys_clk(sys_clk), .levels(levels), .core_channel(core_channel),
        .core_sample(core_sample), .core_trial(core_trial), .core_compare(core_compare));
    // Clock of 50 ns period
    always #25 sys_clk = ~sys_clk;
    // Log the start of every sample phase with its channel
    always @(posedge sys_clk) begin
        cyc++;
        if (core_sample === 1'b1 && samp_d === 1'b0) begin
            rise_t.push_back(cyc);
            rise_ch.push_back(core_channel);
        end
        samp_d = core_sample;
    end
    task automatic wr(input logic [15:0] a, input adcsq_byte_t d);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
        #1;
    endtask
    task automatic chk_reg(input string nm, input logic [15:0] a, input adcsq_byte_t e);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        #1;
        rv = bus_rdata;
        `CHK(nm, e, rv)
    endtask
    task automatic wait_irq(input int bound);
        n = 0;
        while (conv_done_irq !== 1'b1 && n < bound) begin
            @(posedge sys_clk);
            n++;
            #1;
        end
        if (conv_done_irq !== 1'b1) begin failures++; $display("[FAIL] irq wait timed out"); wrap_up(); end
    endtask
    task automatic wait_rises(input int k);
        n = 0;
        while (rise_t.size() < k && n < 2000) begin
            @(posedge sys_clk);
            n++;
        end
        if (rise_t.size() < k) begin failures++; $display("[FAIL] sample wait timed out"); wrap_up(); end
    endtask
    // far side gives a high-to-low edge on the trigger
    task automatic pulse_trigger();
        @(posedge sys_clk);
        ext_trigger_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        ext_trigger_n <= 1'b1;
    endtask
    task automatic wrap_up();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        for (i = 0; i < 8; i++) begin
            lvl[i] = $random(seed) & 255;
            levels[i*8 +: 8] = 8'(lvl[i]);
        end
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        // Reset values, fixed and spare bits, read-only and unmapped places
        for (i = 0; i < 4; i++) chk_reg("result_rst", `ADCSQ_ADDR_RESULT_A + 16'(2*i), 8'h00);
        chk_reg("csr_rst", `ADCSQ_ADDR_CSR, 8'h00);
        chk_reg("tcr_rst", `ADCSQ_ADDR_TCR, 8'h7E);
        chk_reg("unmapped", 16'hFFEC, 8'h00);
        wr(`ADCSQ_ADDR_TCR, 8'h00);
        chk_reg("tcr_fixed", `ADCSQ_ADDR_TCR, 8'h7E);
        wr(`ADCSQ_ADDR_TCR, 8'h01);
        chk_reg("tcr_spare", `ADCSQ_ADDR_TCR, 8'h7F);
        wr(`ADCSQ_ADDR_RESULT_A, 8'h5A);
        chk_reg("result_ro", `ADCSQ_ADDR_RESULT_A, 8'h00);
        $display("test registers done");
        // Trigger ignored while disabled, then starts a masked conversion
        wr(`ADCSQ_ADDR_CSR, 8'h02);
        base = rise_t.size();
        pulse_trigger();
        repeat (300) @(posedge sys_clk);
        `CHK("trig_off", base, rise_t.size())
        wr(`ADCSQ_ADDR_TCR, 8'hFF);
        chk_reg("tcr_on", `ADCSQ_ADDR_TCR, 8'hFF);
        pulse_trigger();
        repeat (260) @(posedge sys_clk);
        #1;
        `CHK("irq_masked", 1'b0, conv_done_irq)
        `CHK("trig_conv", base + 1, rise_t.size())
        chk_reg("csr_trig", `ADCSQ_ADDR_CSR, 8'h82);
        chk_reg("result_c", `ADCSQ_ADDR_RESULT_C, 8'(lvl[2]));
        wr(`ADCSQ_ADDR_CSR, 8'hC2);
        `CHK("irq_on", 1'b1, conv_done_irq)
        chk_reg("csr_w1", `ADCSQ_ADDR_CSR, 8'hC2);
        wr(`ADCSQ_ADDR_CSR, 8'h42);
        `CHK("done_clr", 1'b0, conv_done_irq)
        wr(`ADCSQ_ADDR_TCR, 8'h7E);
        $display("test trigger done");
        // Single conversions on every channel, speeds alternating, end values included
        for (i = 0; i < 8; i++) begin
            lvl[i] = (i == 0) ? 0 : (i == 7) ? 255 : ($random(seed) & 255);
            levels[i*8 +: 8] <= 8'(lvl[i]);
            base = rise_t.size();
            wr(`ADCSQ_ADDR_CSR, 8'(8'h60 + 8*(i%2) + i));
            wait_irq(400);
            `CHK("conv_time", 1'b1, n <= ((i % 2) ? 122 : 242))
            `CHK("channel", i, rise_ch[base])
            chk_reg("result", `ADCSQ_ADDR_RESULT_A + 16'(2*(i%4)), 8'(lvl[i]));
            chk_reg("csr_single", `ADCSQ_ADDR_CSR, 8'(8'hC0 + 8*(i%2) + i));
            `CHK("one_conv", base + 1, rise_t.size())
            wr(`ADCSQ_ADDR_CSR, 8'h40);
            `CHK("irq_clr", 1'b0, conv_done_irq)
        end
        $display("test single done");
        // mode, speed and channels chosen together with start from a stopped state
        base = rise_t.size();
        wr(`ADCSQ_ADDR_CSR, 8'h7E);
        wait_irq(700);
        `CHK("scan_done", 1'b1, (rise_t.size() - base) inside {3, 4})
        for (i = 0; i < 3; i++) chk_reg("scan_res", `ADCSQ_ADDR_RESULT_A + 16'(2*i), 8'(lvl[4+i]));
        chk_reg("scan_res_d", `ADCSQ_ADDR_RESULT_D, 8'(lvl[7]));
        wait_rises(base + 5);
        for (i = 0; i < 5; i++) `CHK("scan_chan", 4 + i % 3, rise_ch[base+i])
        for (i = 2; i < 5; i++) `CHK("scan_len", 128, rise_t[base+i] - rise_t[base+i-1])
        wr(`ADCSQ_ADDR_CSR, 8'h5E);
        base = rise_t.size();
        repeat (300) @(posedge sys_clk);
        `CHK("halted", base, rise_t.size())
        chk_reg("csr_stop", `ADCSQ_ADDR_CSR, 8'hDE);
        wr(`ADCSQ_ADDR_CSR, 8'h7E);
        wait_rises(base + 1);
        `CHK("restart_ch", 4, rise_ch[base])
        @(posedge sys_clk);
        standby_enter <= 1'b1;
        @(posedge sys_clk);
        standby_enter <= 1'b0;
        for (i = 0; i < 4; i++) chk_reg("result_sby", `ADCSQ_ADDR_RESULT_A + 16'(2*i), 8'h00);
        chk_reg("csr_sby", `ADCSQ_ADDR_CSR, 8'h00);
        chk_reg("tcr_sby", `ADCSQ_ADDR_TCR, 8'h7E);
        `CHK("sby_sample", 1'b0, core_sample)
        base = rise_t.size();
        repeat (300) @(posedge sys_clk);
        `CHK("sby_halt", base, rise_t.size())
        `CHK("sby_irq", 1'b0, conv_done_irq)
        $display("test scan done");
        wrap_up();
    end
endmodule
